/* File: logic/bsx_exec.sv */
`timescale 1ns/10ps
// Functional notes
// RULE1 - io bit set forces one selected I/O bit high, two cycles, no flags
// RULE2 - io bit clear forces one selected I/O bit low, two cycles, no flags
// RULE3 - shift left inserts zero at bit 0; updates Z C N V in one cycle
// RULE4 - shift right inserts zero at bit 7; updates Z C N V in one cycle
// RULE5 - signed shift right keeps bit 7; updates Z C N V in one cycle
// RULE6 - rotate left: carry into bit 0, bit 7 into carry, one cycle
// RULE7 - rotate right: carry into bit 7, bit 0 into carry, one cycle
// RULE8 - nibble swap exchanges register halves in one cycle, no flags
// RULE9 - bit capture copies selected register bit into T, one cycle
// RULE10 - bit insert copies T into selected register bit, no flags
// RULE11 - overflow flag set and clear touch only V, one cycle
// RULE12 - sign flag set and clear touch only S, one cycle
// RULE13 - halfcarry flag set and clear touch only H, one cycle
// RULE14 - sleep issues in one cycle, no flags, pulses sleep request
// RULE15 - watchdog restart issues in one cycle, no flags, pulses restart
// RULE16 - indirect load and pointer write move a byte via pointer, two cycles
// RULE17 - copy, immediate, port read and port write: one cycle, no flags
// RULE18 - program memory fetch loads register 0 via pointer, three cycles
module bsx_exec
  import bsx_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic instr_valid, // instruction offered
  input wire bsx_instr_t instr, // decoded instruction
  input wire logic [15:0] ptr, // indirect pointer
  input wire logic [7:0] prog_byte, // program memory byte at ptr
  output logic instr_ready, // ready to take an instruction
  output logic done, // one-cycle pulse at completion
  output logic [7:0] status_flags_reg, // status flags
  output logic [7:0] reg0, // register 0 view
  output logic [7:0] io_view, // I/O register 0 view
  output logic sleep_req, // sleep request pulse
  output logic watchdog_restart // watchdog restart pulse
);
  bsx_state_t fsm_q, fsm_d;
  logic rdy_q, rdy_d;
  logic [1:0] cnt_q, cnt_d;
  bsx_instr_t cur_q, cur_d;
  logic [7:0] regs_q [NUM_REGS];
  logic [7:0] regs_d [NUM_REGS];
  logic [7:0] io_q [NUM_IO];
  logic [7:0] io_d [NUM_IO];
  logic [7:0] mem_q [DATA_WORDS];
  logic [7:0] mem_d [DATA_WORDS];
  logic [7:0] sr_q, sr_d;
  logic done_q, done_d, slp_q, slp_d, wdog_q, wdog_d;
  logic [7:0] a, r;
  logic c_new, n_new, v_new;
  logic alu;
  bsx_instr_t ex;
  logic fire;

  // multi-cycle ops commit on their last cycle; single-cycle ops on accept
  always_comb begin
    fsm_d = fsm_q;
    cnt_d = cnt_q;
    cur_d = cur_q;
    fire = 1'b0;
    ex = cur_q;
    if (fsm_q == FSM_IDLE) begin
      if (instr_valid) begin
        cur_d = instr;
        unique case (instr.op)
          OP_IO_BIT_SET, OP_IO_BIT_CLEAR, OP_INDIRECT_LOAD, OP_POINTER_WRITE: begin
            fsm_d = FSM_BUSY; // see RULE1 see RULE2 see RULE16
            cnt_d = CYC_TWO - CYC_ONE;
          end
          OP_PROGRAM_MEMORY_FETCH: begin
            fsm_d = FSM_BUSY; // see RULE18
            cnt_d = CYC_THREE - CYC_ONE;
          end
          default: begin
            fire = 1'b1;
            ex = instr;
          end
        endcase
      end
    end else begin
      cnt_d = cnt_q - CYC_ONE;
      if (cnt_q == CYC_ONE) begin
        fsm_d = FSM_IDLE;
        fire = 1'b1;
      end
    end
    // ready kept in its own flop so the port has no decode behind it
    rdy_d = (fsm_d == FSM_IDLE);
  end

  // shift and rotate datapath
  always_comb begin
    a = regs_q[ex.rd];
    r = a;
    c_new = sr_q[FLG_C];
    alu = 1'b1;
    unique case (ex.op)
      OP_SHIFT_LEFT_LOGICAL: begin r = {a[6:0], 1'b0}; c_new = a[7]; end // see RULE3
      OP_SHIFT_RIGHT_LOGICAL: begin r = {1'b0, a[7:1]}; c_new = a[0]; end // see RULE4
      OP_SHIFT_RIGHT_SIGNED: begin r = {a[7], a[7:1]}; c_new = a[0]; end // see RULE5
      OP_ROTATE_LEFT_CARRY: begin r = {a[6:0], sr_q[FLG_C]}; c_new = a[7]; end // see RULE6
      OP_ROTATE_RIGHT_CARRY: begin r = {sr_q[FLG_C], a[7:1]}; c_new = a[0]; end // see RULE7
      default: alu = 1'b0;
    endcase
    n_new = r[7];
    v_new = n_new ^ c_new; // overflow follows N xor C for shifts
  end

  // architectural state update
  always_comb begin
    regs_d = regs_q;
    io_d = io_q;
    mem_d = mem_q;
    sr_d = sr_q;
    done_d = fire;
    slp_d = 1'b0;
    wdog_d = 1'b0;
    if (fire) begin
      if (alu) begin
        regs_d[ex.rd] = r;
        sr_d[FLG_Z] = (r == 8'h00);
        sr_d[FLG_C] = c_new;
        sr_d[FLG_N] = n_new;
        sr_d[FLG_V] = v_new;
      end
      unique case (ex.op)
        OP_IO_BIT_SET: io_d[ex.port][ex.bitsel] = 1'b1; // see RULE1
        OP_IO_BIT_CLEAR: io_d[ex.port][ex.bitsel] = 1'b0; // see RULE2
        OP_NIBBLE_SWAP: regs_d[ex.rd] = {a[3:0], a[7:4]}; // see RULE8
        OP_FLAG_BIT_CAPTURE: sr_d[FLG_T] = regs_q[ex.rr][ex.bitsel]; // see RULE9
        OP_FLAG_BIT_INSERT: regs_d[ex.rd][ex.bitsel] = sr_q[FLG_T]; // see RULE10
        OP_OVERFLOW_FLAG_SET: sr_d[FLG_V] = 1'b1; // see RULE11
        OP_OVERFLOW_FLAG_CLEAR: sr_d[FLG_V] = 1'b0; // see RULE11
        OP_SIGN_FLAG_SET: sr_d[FLG_S] = 1'b1; // see RULE12
        OP_SIGN_FLAG_CLEAR: sr_d[FLG_S] = 1'b0; // see RULE12
        OP_HALFCARRY_FLAG_SET: sr_d[FLG_H] = 1'b1; // see RULE13
        OP_HALFCARRY_FLAG_CLEAR: sr_d[FLG_H] = 1'b0; // see RULE13
        OP_SLEEP: slp_d = 1'b1; // see RULE14
        OP_WATCHDOG_RESTART: wdog_d = 1'b1; // see RULE15
        OP_INDIRECT_LOAD: regs_d[ex.rd] = mem_q[ptr[5:0]]; // see RULE16
        OP_POINTER_WRITE: mem_d[ptr[5:0]] = regs_q[ex.rr]; // see RULE16
        OP_REGISTER_COPY: regs_d[ex.rd] = regs_q[ex.rr]; // see RULE17
        OP_IMMEDIATE_LOAD: regs_d[ex.rd] = ex.imm; // see RULE17
        OP_PORT_READ: regs_d[ex.rd] = io_q[ex.port]; // see RULE17
        OP_PORT_WRITE: io_d[ex.port] = regs_q[ex.rr]; // see RULE17
        OP_PROGRAM_MEMORY_FETCH: regs_d[0] = prog_byte; // see RULE18
        default: ;
      endcase
    end
  end

  // register everything; storage is plain flip-flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fsm_q <= FSM_IDLE;
      rdy_q <= 1'b1;
      cnt_q <= 2'h0;
      cur_q <= '0;
      sr_q <= STATUS_RST;
      done_q <= 1'b0;
      slp_q <= 1'b0;
      wdog_q <= 1'b0;
      for (int i = 0; i < NUM_REGS; i++) regs_q[i] <= REG_RST;
      for (int i = 0; i < NUM_IO; i++) io_q[i] <= IO_RST;
      for (int i = 0; i < DATA_WORDS; i++) mem_q[i] <= REG_RST;
    end else begin
      fsm_q <= fsm_d;
      rdy_q <= rdy_d;
      cnt_q <= cnt_d;
      cur_q <= cur_d;
      sr_q <= sr_d;
      done_q <= done_d;
      slp_q <= slp_d;
      wdog_q <= wdog_d;
      regs_q <= regs_d;
      io_q <= io_d;
      mem_q <= mem_d;
    end
  end

  // ready is low while a multi-cycle op runs; all from flops
  assign instr_ready = rdy_q;
  assign done = done_q;
  assign status_flags_reg = sr_q;
  assign reg0 = regs_q[0];
  assign io_view = io_q[0];
  assign sleep_req = slp_q;
  assign watchdog_restart = wdog_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_bitset_two_cyc: assert property (instr_valid && instr_ready && instr.op == OP_IO_BIT_SET |=> !instr_ready ##1 done) // see RULE1
    else $error("io bit set not two cycles");
  a_bitclr_value: assert property (instr_valid && instr_ready && instr.op == OP_IO_BIT_CLEAR && instr.port == 6'h00
    |-> ##2 !io_view[$past(instr.bitsel, 2)]) // see RULE2
    else $error("io bit clear wrong value");
  a_shl_result: assert property (instr_valid && instr_ready && instr.op == OP_SHIFT_LEFT_LOGICAL && instr.rd == 5'h00
    |=> reg0 == {$past(reg0[6:0]), 1'b0} && status_flags_reg[FLG_C] == $past(reg0[7])) // see RULE3
    else $error("shift left wrong");
  a_shr_flags: assert property (instr_valid && instr_ready && instr.op == OP_SHIFT_RIGHT_LOGICAL && instr.rd == 5'h00
    |=> !reg0[7] && status_flags_reg[FLG_Z] == (reg0 == 8'h00)) // see RULE4
    else $error("shift right wrong");
  a_signed_shift_sign: assert property (instr_valid && instr_ready && instr.op == OP_SHIFT_RIGHT_SIGNED && instr.rd == 5'h00
    |=> reg0[7] == $past(reg0[7]) && status_flags_reg[FLG_N] == reg0[7]) // see RULE5
    else $error("signed shift wrong");
  a_rotl_carry: assert property (instr_valid && instr_ready && instr.op == OP_ROTATE_LEFT_CARRY && instr.rd == 5'h00
    |=> reg0[0] == $past(status_flags_reg[FLG_C])) // see RULE6
    else $error("rotate left wrong");
  a_rotr_carry: assert property (instr_valid && instr_ready && instr.op == OP_ROTATE_RIGHT_CARRY && instr.rd == 5'h00
    |=> reg0[7] == $past(status_flags_reg[FLG_C]) && status_flags_reg[FLG_C] == $past(reg0[0])) // see RULE7
    else $error("rotate right wrong");
  a_swap_noflag: assert property (instr_valid && instr_ready && instr.op == OP_NIBBLE_SWAP
    |=> $stable(status_flags_reg)) // see RULE8
    else $error("swap changed flags");
  a_ovf_only: assert property (instr_valid && instr_ready && instr.op == OP_OVERFLOW_FLAG_SET
    |=> status_flags_reg == ($past(status_flags_reg) | 8'h08)) // see RULE11
    else $error("overflow set wrong");
  a_fetch_three: assert property (instr_valid && instr_ready && instr.op == OP_PROGRAM_MEMORY_FETCH
    |=> !instr_ready [*2] ##1 done) // see RULE18
    else $error("fetch not three cycles");
  a_restart_pulse: assert property (instr_valid && instr_ready && instr.op == OP_WATCHDOG_RESTART
    |=> watchdog_restart ##1 !watchdog_restart) // see RULE15
    else $error("restart pulse wrong");

  c_bitset: cover property (instr_valid && instr_ready && instr.op == OP_IO_BIT_SET ##2 done);
  c_rotate: cover property (instr_valid && instr_ready && instr.op == OP_ROTATE_LEFT_CARRY);
  c_fetch: cover property (instr_valid && instr_ready && instr.op == OP_PROGRAM_MEMORY_FETCH ##3 done);
endmodule

/* File: logic/bsx_pkg.sv */
package bsx_pkg;
  // status register bit positions
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_H = 5;
  localparam int unsigned FLG_T = 6;
  localparam int unsigned FLG_I = 7;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] IO_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  // cycle counts per instruction class
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam int unsigned NUM_REGS = 32;
  localparam int unsigned NUM_IO = 64;
  localparam int unsigned DATA_WORDS = 64;
  localparam int unsigned PROG_BYTES = 256;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_INDIRECT_LOAD = 5'h01, OP_POINTER_WRITE = 5'h02,
    OP_REGISTER_COPY = 5'h03, OP_IMMEDIATE_LOAD = 5'h04, OP_PORT_READ = 5'h05,
    OP_PORT_WRITE = 5'h06, OP_PROGRAM_MEMORY_FETCH = 5'h07, OP_IO_BIT_SET = 5'h08,
    OP_IO_BIT_CLEAR = 5'h09, OP_SHIFT_LEFT_LOGICAL = 5'h0A, OP_SHIFT_RIGHT_LOGICAL = 5'h0B,
    OP_SHIFT_RIGHT_SIGNED = 5'h0C, OP_ROTATE_LEFT_CARRY = 5'h0D, OP_ROTATE_RIGHT_CARRY = 5'h0E,
    OP_NIBBLE_SWAP = 5'h0F, OP_FLAG_BIT_CAPTURE = 5'h10, OP_FLAG_BIT_INSERT = 5'h11,
    OP_OVERFLOW_FLAG_SET = 5'h12, OP_OVERFLOW_FLAG_CLEAR = 5'h13, OP_SIGN_FLAG_SET = 5'h14,
    OP_SIGN_FLAG_CLEAR = 5'h15, OP_HALFCARRY_FLAG_SET = 5'h16, OP_HALFCARRY_FLAG_CLEAR = 5'h17,
    OP_SLEEP = 5'h18, OP_WATCHDOG_RESTART = 5'h19
  } bsx_op_t;

  // one decoded instruction as handed in by the fetch stage
  typedef struct packed {
    bsx_op_t op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [5:0] port;
    logic [2:0] bitsel;
    logic [7:0] imm;
  } bsx_instr_t;

  typedef enum logic [1:0] {
    FSM_IDLE = 2'b00,
    FSM_BUSY = 2'b01
  } bsx_state_t;
endpackage

/* File: test/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import bsx_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  bsx_instr_t instr = '0;
  logic [15:0] ptr = 16'h0000;
  logic [7:0] prog_byte = 8'h00;
  logic instr_ready, done, sleep_req, watchdog_restart;
  logic [7:0] status_flags_reg, reg0, io_view;
  // reference state; only register 0 and I/O 0 are visible at the ports
  logic [7:0] rf [NUM_REGS];
  logic [7:0] io [NUM_IO];
  logic [7:0] mem [DATA_WORDS];
  logic [7:0] flg;
  logic [5:0] last_addr = 6'h00;
  logic wrote = 1'b0;
  int err_count = 0;
  int check_count = 0;

  bsx_exec dut (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr), .ptr(ptr),
    .prog_byte(prog_byte), .instr_ready(instr_ready), .done(done), .status_flags_reg(status_flags_reg),
    .reg0(reg0), .io_view(io_view), .sleep_req(sleep_req), .watchdog_restart(watchdog_restart));

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // latency from accept edge to completion
  function automatic int cycles_of(bsx_op_t op);
    case (op)
      OP_IO_BIT_SET, OP_IO_BIT_CLEAR, OP_INDIRECT_LOAD, OP_POINTER_WRITE: return CYC_TWO;
      OP_PROGRAM_MEMORY_FETCH: return CYC_THREE;
      default: return CYC_ONE;
    endcase
  endfunction

  // reference update; shifts also drive V as N xor C, S stays put
  function automatic void model(bsx_instr_t i);
    logic [7:0] s, r;
    logic c;
    s = rf[i.rd];
    c = flg[FLG_C];
    r = s;
    case (i.op)
      OP_INDIRECT_LOAD: rf[i.rd] = mem[ptr[5:0]];
      OP_POINTER_WRITE: mem[ptr[5:0]] = rf[i.rr];
      OP_REGISTER_COPY: rf[i.rd] = rf[i.rr];
      OP_IMMEDIATE_LOAD: rf[i.rd] = i.imm;
      OP_PORT_READ: rf[i.rd] = io[i.port];
      OP_PORT_WRITE: io[i.port] = rf[i.rr];
      OP_PROGRAM_MEMORY_FETCH: rf[0] = prog_byte;
      OP_IO_BIT_SET: io[i.port][i.bitsel] = 1'b1;
      OP_IO_BIT_CLEAR: io[i.port][i.bitsel] = 1'b0;
      OP_SHIFT_LEFT_LOGICAL: begin r = {s[6:0], 1'b0}; c = s[7]; end
      OP_SHIFT_RIGHT_LOGICAL: begin r = {1'b0, s[7:1]}; c = s[0]; end
      OP_SHIFT_RIGHT_SIGNED: begin r = {s[7], s[7:1]}; c = s[0]; end
      OP_ROTATE_LEFT_CARRY: begin r = {s[6:0], c}; c = s[7]; end
      OP_ROTATE_RIGHT_CARRY: begin r = {c, s[7:1]}; c = s[0]; end
      OP_NIBBLE_SWAP: rf[i.rd] = {s[3:0], s[7:4]};
      OP_FLAG_BIT_CAPTURE: flg[FLG_T] = rf[i.rr][i.bitsel];
      OP_FLAG_BIT_INSERT: rf[i.rd][i.bitsel] = flg[FLG_T];
      // even codes set, odd codes clear
      OP_OVERFLOW_FLAG_SET, OP_OVERFLOW_FLAG_CLEAR: flg[FLG_V] = ~i.op[0];
      OP_SIGN_FLAG_SET, OP_SIGN_FLAG_CLEAR: flg[FLG_S] = ~i.op[0];
      OP_HALFCARRY_FLAG_SET, OP_HALFCARRY_FLAG_CLEAR: flg[FLG_H] = ~i.op[0];
      default: ;
    endcase
    if (i.op inside {[OP_SHIFT_LEFT_LOGICAL:OP_ROTATE_RIGHT_CARRY]}) begin
      rf[i.rd] = r;
      flg[FLG_C] = c;
      flg[FLG_Z] = (r == 8'h00);
      flg[FLG_N] = r[7];
      flg[FLG_V] = r[7] ^ c;
    end
  endfunction

  // one instruction: offer, accept, then watch every cycle until completion
  task automatic run(input bsx_instr_t i);
    int n;
    n = cycles_of(i.op);
    if (i.op == OP_INDIRECT_LOAD && !wrote) i.op = OP_POINTER_WRITE;
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr <= i;
    prog_byte <= 8'($urandom);
    // loads only from an address already written, the reference memory mem has no initial value
    ptr <= (i.op == OP_INDIRECT_LOAD) ? {10'($urandom), last_addr} : 16'($urandom);
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    if (i.op == OP_POINTER_WRITE) begin
      last_addr = ptr[5:0];
      wrote = 1'b1;
    end
    model(i);
    // k counts edges from the accept edge itself; a one-cycle op shows done right after it
    for (int k = 1; k <= n; k++) begin
      if (k > 1) @(posedge clk_sys);
      #1;
      chk({6'h00, done, instr_ready}, {6'h00, k == n, k == n});
    end
    chk(reg0, rf[0]);
    chk(io_view, io[0]);
    chk(status_flags_reg, flg);
    chk({6'h00, sleep_req, watchdog_restart}, {6'h00, i.op == OP_SLEEP, i.op == OP_WATCHDOG_RESTART});
  endtask

  function automatic bsx_instr_t pick(int op);
    bsx_instr_t i;
    i.op = bsx_op_t'(op);
    i.rd = $urandom_range(2) == 0 ? 5'h05 : 5'h00;
    i.rr = $urandom_range(2) == 0 ? 5'h05 : 5'h00;
    i.port = $urandom_range(2) == 0 ? 6'h03 : 6'h00;
    i.bitsel = 3'($urandom);
    i.imm = 8'($urandom);
    return i;
  endfunction

  initial begin
    bsx_instr_t i;
    for (int a = 0; a < NUM_REGS; a++) rf[a] = REG_RST;
    for (int a = 0; a < NUM_IO; a++) io[a] = IO_RST;
    flg = STATUS_RST;
    void'($urandom(86));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk(status_flags_reg, STATUS_RST);
    chk(reg0, REG_RST);
    chk(io_view, IO_RST);
    chk({4'h0, instr_ready, done, sleep_req, watchdog_restart}, 8'h08);
    // corners: sign bit alone and lowest bit alone through each shift and rotate
    for (int v = 0; v < 10; v++) begin
      i = pick(OP_IMMEDIATE_LOAD);
      i.rd = 5'h00;
      i.imm = v[0] ? 8'h80 : 8'h01;
      run(i);
      i.op = bsx_op_t'(OP_SHIFT_LEFT_LOGICAL + v / 2);
      run(i);
    end
    // every code once (indirect load runs as a pointer write, nothing written yet), then a random mix
    for (int op = 0; op <= OP_WATCHDOG_RESTART; op++) run(pick(op));
    repeat (400) run(pick($urandom_range(OP_WATCHDOG_RESTART)));
    test_done();
  end

  // about 1000 cycles expected; cut a hang well beyond that
  initial begin
    #200000;
    err_count++;
    test_done();
  end
endmodule
